// [include/acc_pkg.sv]
// Package for the second analog comparator control block: offsets, fields, resets, timing.
// Assumes an AXI4-Lite master with 32-bit data and a 10 MHz system clock.
package acc_pkg;
    // Register byte offsets (printed offset 0xAD is not a multiple of four: index form)
    localparam logic [7:0]  ACC_CTRL_IDX    = 8'hAD;
    localparam logic [11:0] ACC_CTRL_ADDR   = {2'h0, ACC_CTRL_IDX, 2'h0};
    localparam logic [11:0] ACC_STAT_ADDR   = 12'h400;
    localparam logic [11:0] ACC_MASK_ADDR   = 12'h404;
    // Control field positions
    localparam int          ACC_HYS_BIT     = 6;
    localparam int          ACC_EN_BIT      = 5;
    localparam int          ACC_PAIR_BIT    = 4;
    localparam int          ACC_NREF_BIT    = 3;
    localparam int          ACC_OE_BIT      = 2;
    localparam int          ACC_RES_BIT     = 1;
    localparam int          ACC_FLAG_BIT    = 0;
    // Writable control bits (bit 0 only by a zero write)
    localparam logic [7:0]  ACC_CTRL_WMASK  = 8'h7C;
    localparam logic [7:0]  ACC_CTRL_RESET  = 8'h00;
    // Interrupt status layout: bit 0 change event
    localparam logic [1:0]  ACC_IRQ_RESET   = 2'h0;
    localparam int          ACC_EV_CHANGE   = 0;
    localparam int          ACC_EV_ENABLE   = 1;
    // AXI responses
    localparam logic [1:0]  ACC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  ACC_RESP_SLVERR = 2'h2;
    // Settling time after enabling
    localparam int          ACC_CLK_HZ      = 10_000_000;
    localparam int          ACC_SETTLE_US   = 10;
    localparam int          ACC_SETTLE_CYC  = (ACC_SETTLE_US * ACC_CLK_HZ + 999_999) / 1_000_000;
endpackage

// [hw/acc_sync.sv]
// Two-stage synchronizer for one level from the analog comparator.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/1ps
module acc_sync
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // Level in and out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_q;
    logic sync_q;

    // First stage is read only by the second
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// [hw/acc_top.sv]
// Control and status of the second analog comparator, reached over AXI4-Lite.
// Assumes the analog core takes the control levels and returns its raw output.
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ps
module acc_top
    import acc_pkg::*;
(
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst,
    // AXI4-Lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Analog core
    input  wire logic        comp_raw,
    output logic             hysteresis_enable,
    output logic             comparator_enable,
    output logic             input_pair_select,
    output logic             negative_ref_select,
    // Output pin and interrupt
    output logic             comparator_output_pin,
    output logic             irq
);
    // Registers
    logic [7:0]  ctrl_q;
    logic        flag_q;
    logic        res_q;
    logic        res_prev_q;
    logic [1:0]  stat_q;
    logic [1:0]  mask_q;
    logic        irq_q;
    logic        pin_q;
    logic        settled_q;
    logic [7:0]  settle_cnt_q;
    logic        aw_hold_q;
    logic        w_hold_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;

    // Synchronizer for the comparator output
    logic comp_sync;
    acc_sync u_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (comp_raw),
        .sync_out (comp_sync)
    );

    // Write decode: fire once address and data are each held or taken this cycle, response slot free
    wire         aw_take    = s_axi_awvalid && !aw_hold_q && !bvalid_q;
    wire         w_take     = s_axi_wvalid && !w_hold_q && !bvalid_q;
    wire [11:0]  wr_addr    = aw_hold_q ? aw_addr_q : s_axi_awaddr;
    wire [31:0]  wr_data    = w_hold_q ? w_data_q : s_axi_wdata;
    wire [3:0]   wr_strb    = w_hold_q ? w_strb_q : s_axi_wstrb;
    wire         wr_fire    = (aw_hold_q || aw_take) && (w_hold_q || w_take);
    wire         wr_ctrl    = wr_fire && (wr_addr == ACC_CTRL_ADDR) && wr_strb[0];
    wire         wr_mask    = wr_fire && (wr_addr == ACC_MASK_ADDR) && wr_strb[0];
    wire         wr_hit     = (wr_addr == ACC_CTRL_ADDR) || (wr_addr == ACC_MASK_ADDR)
                              || (wr_addr == ACC_STAT_ADDR);

    // Read decode
    wire         rd_fire    = s_axi_arvalid && !rvalid_q;
    wire         rd_stat    = rd_fire && (s_axi_araddr == ACC_STAT_ADDR);
    wire [7:0]   ctrl_view  = {1'b0, ctrl_q[ACC_HYS_BIT:ACC_OE_BIT], res_q, flag_q};
    wire         rd_hit     = (s_axi_araddr == ACC_CTRL_ADDR) || (s_axi_araddr == ACC_MASK_ADDR)
                              || (s_axi_araddr == ACC_STAT_ADDR);
    wire [31:0]  rd_word    = (s_axi_araddr == ACC_CTRL_ADDR) ? {24'h0, ctrl_view} :
                              (s_axi_araddr == ACC_STAT_ADDR) ? {30'h0, stat_q} :
                              (s_axi_araddr == ACC_MASK_ADDR) ? {30'h0, mask_q} : 32'h0;

    // Comparator state
    wire         en         = ctrl_q[ACC_EN_BIT];
    wire [7:0]   ctrl_new   = (ctrl_q & ~ACC_CTRL_WMASK) | (wr_data[7:0] & ACC_CTRL_WMASK);
    wire         en_next    = wr_ctrl ? ctrl_new[ACC_EN_BIT] : en;
    wire         res_d      = en && comp_sync;
    wire         change     = en && (comp_sync != res_prev_q);
    wire         flag_clr   = wr_ctrl && !wr_data[ACC_FLAG_BIT];
    wire         flag_d     = !en ? 1'b0 : (change ? 1'b1 : (flag_clr ? 1'b0 : flag_q));
    wire         settle_end = (settle_cnt_q == 8'(ACC_SETTLE_CYC - 1));
    wire         en_rise    = en && !settled_q && settle_end;
    wire [1:0]   events     = {en_rise, change};
    wire [1:0]   stat_d     = events | (rd_stat ? 2'h0 : stat_q);      // set beats read clear
    wire         pin_d      = en && ctrl_q[ACC_OE_BIT] && comp_raw;

    // Control register, bits 6..2 software-owned
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= ACC_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_new;
        end
    end

    // Result, edge history and change flag
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            res_q      <= 1'b0;
            res_prev_q <= 1'b0;
            flag_q     <= 1'b0;
        end else begin
            res_q      <= res_d;
            res_prev_q <= en ? comp_sync : 1'b0;
            flag_q     <= flag_d;
        end
    end

    // Settling timer after enable: status bit tells software the output is usable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            settle_cnt_q <= 8'h00;
            settled_q    <= 1'b0;
        end else if (!en_next) begin
            settle_cnt_q <= 8'h00;
            settled_q    <= 1'b0;
        end else if (!settled_q) begin
            settle_cnt_q <= settle_end ? settle_cnt_q : settle_cnt_q + 8'h01;
            settled_q    <= settle_end;
        end
    end

    // Interrupt status, mask and output; pin retimed since outputs come from flops
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stat_q <= ACC_IRQ_RESET;
            mask_q <= ACC_IRQ_RESET;
            irq_q  <= 1'b0;
            pin_q  <= 1'b0;
        end else begin
            stat_q <= stat_d;
            mask_q <= wr_mask ? wr_data[1:0] : mask_q;
            irq_q  <= |(stat_d & mask_q);
            pin_q  <= pin_d;
        end
    end

    // Write channel holding and response
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= ACC_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_addr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            aw_hold_q <= wr_fire ? 1'b0 : (aw_hold_q || aw_take);
            w_hold_q  <= wr_fire ? 1'b0 : (w_hold_q || w_take);
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= ACC_RESP_OKAY;
            rdata_q  <= 32'h0000_0000;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
            rresp_q  <= rd_hit ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
            rdata_q  <= rd_word;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Port drive, from flops except awready, wready and arready
    assign s_axi_awready         = aw_take;
    assign s_axi_wready          = w_take;
    assign s_axi_bvalid          = bvalid_q;
    assign s_axi_bresp           = bresp_q;
    assign s_axi_arready         = rd_fire;
    assign s_axi_rvalid          = rvalid_q;
    assign s_axi_rresp           = rresp_q;
    assign s_axi_rdata           = rdata_q;
    assign hysteresis_enable     = ctrl_q[ACC_HYS_BIT];
    assign comparator_enable     = ctrl_q[ACC_EN_BIT];
    assign input_pair_select     = ctrl_q[ACC_PAIR_BIT];
    assign negative_ref_select   = ctrl_q[ACC_NREF_BIT];
    assign comparator_output_pin = pin_q;
    assign irq                   = irq_q;

    // Result zero whenever disabled one cycle earlier
    a_result_off: assert property (@(posedge sys_clk) disable iff (rst)
        !$past(en) |-> !res_q) else $error("result set while disabled");
    // Flag cleared one cycle after disable
    a_flag_off: assert property (@(posedge sys_clk) disable iff (rst)
        !en |=> !flag_q) else $error("flag set while disabled");
    // A change of the synchronized result while enabled sets the flag
    a_flag_set: assert property (@(posedge sys_clk) disable iff (rst)
        (en && comp_sync != res_prev_q) |=> flag_q) else $error("change missed");
    // Flag never rises without a change
    a_flag_cause: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(flag_q) |-> $past(change)) else $error("flag set without change");
    // Pin follows raw output only when enabled and routed
    a_pin_gate: assert property (@(posedge sys_clk) disable iff (rst)
        comparator_output_pin |-> $past(en && ctrl_q[ACC_OE_BIT])) else $error("pin leak");
    // Reserved, result and flag positions of the stored control byte never take a write
    a_reserved_zero: assert property (@(posedge sys_clk) disable iff (rst)
        !ctrl_q[7] && !ctrl_q[ACC_RES_BIT] && !ctrl_q[ACC_FLAG_BIT]) else $error("bad ctrl bit");
    // Hysteresis output tracks control written one cycle before
    a_hys_write: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> hysteresis_enable == $past(wr_data[ACC_HYS_BIT])) else $error("hys lost");
    // Pair and reference selects keep when no control write
    a_sel_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_ctrl |=> $stable({input_pair_select, negative_ref_select}))
        else $error("select moved");
    // Zero write to flag without change clears it
    a_flag_clear: assert property (@(posedge sys_clk) disable iff (rst)
        (flag_clr && !change) |=> !flag_q) else $error("flag not cleared");
    // Not settled within eight cycles of enable rising when enable stays
    a_settle_time: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(en) ##0 (en && !wr_ctrl)[*8] |-> !settled_q) else $error("settled early");
    // Reference select follows a write
    a_nref_write: assert property (@(posedge sys_clk) disable iff (rst)
        wr_ctrl |=> negative_ref_select == $past(wr_data[ACC_NREF_BIT])) else $error("nref lost");
endmodule

// [sim/acc_core_model.sv]
// Behavioural model of the second analog comparator core and its input pins.
// Assumes the bench drives the pin voltages as 8-bit codes on the sys_clk edge.
`timescale 1ns/1ps
module acc_core_model #(
    parameter logic [7:0] INT_REF = 8'h80,   // Internal reference code
    parameter logic [7:0] HYST    = 8'h14    // Hysteresis band when switched on
) (
    // Control levels from the block
    input  wire logic       hysteresis_enable,
    input  wire logic       comparator_enable,
    input  wire logic       input_pair_select,
    input  wire logic       negative_ref_select,
    // Analog inputs as codes
    input  wire logic [7:0] pos_input_first,
    input  wire logic [7:0] pos_input_second,
    input  wire logic [7:0] external_reference_pin,
    // Raw comparator output
    output logic            comp_raw
);
    // Input pair and negative source selection
    wire [8:0] pos_sel = {1'b0, input_pair_select ? pos_input_second : pos_input_first};
    wire [8:0] neg_sel = {1'b0, negative_ref_select ? INT_REF : external_reference_pin};
    wire [8:0] band    = {1'b0, hysteresis_enable ? HYST : 8'h00};
    // Output holds inside the band, so the core is not kinder than a real one
    always @(*) begin
        if (!comparator_enable)
            comp_raw = 1'b0;
        else if (pos_sel > neg_sel + band)
            comp_raw = 1'b1;
        else if (pos_sel + band < neg_sel)
            comp_raw = 1'b0;
    end
endmodule

// [sim/testbench.sv]
// Self-checking bench for the comparator control block over AXI4-Lite.
// Assumes the core model file is compiled first and a 10 MHz clock.
`timescale 1ns/1ps
module testbench;
    import acc_pkg::*;
    logic        sys_clk, rst, comp_raw;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, irq, comparator_output_pin;
    logic        hysteresis_enable, comparator_enable, input_pair_select, negative_ref_select;
    logic [7:0]  pos_a, pos_b, ext_ref;
    int          error_cnt, comparisons;

    acc_top dut_u (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .comp_raw(comp_raw),
        .hysteresis_enable(hysteresis_enable), .comparator_enable(comparator_enable),
        .input_pair_select(input_pair_select), .negative_ref_select(negative_ref_select),
        .comparator_output_pin(comparator_output_pin), .irq(irq));
    acc_core_model core_u (.hysteresis_enable(hysteresis_enable),
        .comparator_enable(comparator_enable), .input_pair_select(input_pair_select),
        .negative_ref_select(negative_ref_select), .pos_input_first(pos_a),
        .pos_input_second(pos_b), .external_reference_pin(ext_ref), .comp_raw(comp_raw));

    // Clock generation
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    // Compare one result, widened to a word
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Write: address and data offered together, each released when taken
    // No cycle limit here: only the watchdog may end a wait for the response
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask

    // Read one word and compare data and response
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'b0;
    endtask

    task automatic complete_run();
        $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        complete_run();
    end

    // Main sequence
    initial begin
        error_cnt = 0;
        comparisons = 0;
        rst = 1'b1;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        pos_a = 8'h00;
        pos_b = 8'h00;
        ext_ref = 8'hE0;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(ACC_CTRL_ADDR, 32'h0, ACC_RESP_OKAY);
        rd_chk(ACC_MASK_ADDR, 32'h0, ACC_RESP_OKAY);
        axi_wr(ACC_MASK_ADDR, 32'h1, ACC_RESP_OKAY);
        axi_wr(ACC_CTRL_ADDR, 32'hFF, ACC_RESP_OKAY);
        // Let the core settle before trusting its output
        repeat (ACC_SETTLE_CYC + 2) @(posedge sys_clk);
        chk("ctrl_pins", 32'hF, {28'h0, hysteresis_enable, comparator_enable,
            input_pair_select, negative_ref_select});
        rd_chk(ACC_CTRL_ADDR, 32'h7C, ACC_RESP_OKAY);
        // Unselected pair moves: no effect
        pos_a <= 8'hC0;
        repeat (8) @(posedge sys_clk);
        rd_chk(ACC_CTRL_ADDR, 32'h7C, ACC_RESP_OKAY);
        pos_b <= 8'hC0;
        repeat (8) @(posedge sys_clk);
        rd_chk(ACC_CTRL_ADDR, 32'h7F, ACC_RESP_OKAY);
        chk("pin", 32'h1, {31'h0, comparator_output_pin});
        chk("irq", 32'h1, {31'h0, irq});
        rd_chk(ACC_STAT_ADDR, 32'h3, ACC_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk("irq_cleared", 32'h0, {31'h0, irq});
        axi_wr(ACC_CTRL_ADDR, 32'h7C, ACC_RESP_OKAY);
        rd_chk(ACC_CTRL_ADDR, 32'h7E, ACC_RESP_OKAY);
        repeat (10) @(posedge sys_clk);
        rd_chk(ACC_CTRL_ADDR, 32'h7E, ACC_RESP_OKAY);
        axi_wr(ACC_CTRL_ADDR, 32'h78, ACC_RESP_OKAY);
        repeat (2) @(posedge sys_clk);
        chk("pin_off", 32'h0, {31'h0, comparator_output_pin});
        pos_b <= 8'h00;
        repeat (8) @(posedge sys_clk);
        rd_chk(ACC_CTRL_ADDR, 32'h79, ACC_RESP_OKAY);
        axi_wr(ACC_CTRL_ADDR, 32'h00, ACC_RESP_OKAY);
        rd_chk(ACC_CTRL_ADDR, 32'h00, ACC_RESP_OKAY);
        chk("enable", 32'h0, {31'h0, comparator_enable});
        // Masked event must not reach the interrupt line
        axi_wr(ACC_MASK_ADDR, 32'h0, ACC_RESP_OKAY);
        // External reference above the input, internal one below: only the select decides
        axi_wr(ACC_CTRL_ADDR, 32'h20, ACC_RESP_OKAY);
        repeat (8) @(posedge sys_clk);
        rd_chk(ACC_CTRL_ADDR, 32'h20, ACC_RESP_OKAY);
        axi_wr(ACC_CTRL_ADDR, 32'h28, ACC_RESP_OKAY);
        repeat (8) @(posedge sys_clk);
        rd_chk(ACC_CTRL_ADDR, 32'h2B, ACC_RESP_OKAY);
        chk("irq_masked", 32'h0, {31'h0, irq});
        rd_chk(12'h010, 32'h0, ACC_RESP_SLVERR);
        axi_wr(12'h010, 32'h0, ACC_RESP_SLVERR);
        complete_run();
    end
endmodule
